// ### shared/trig_cfg_pkg.sv
// Purpose: shared constants and types for trigger handling and the configuration menu
// Assumes: 10 MHz system clock; 32-bit Avalon-MM register slave
// Notes: every offset, timing count and write field position lives here; menu readback bits 30 and 29 and register reset values are set in the modules
package trig_cfg_pkg;
    // timing
    localparam int CLK_HZ = 10000000;
    localparam int TICK_MS = 1;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int MAX_WIDTH_MS = 60;
    localparam int ADDR_W = 4;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_TRIG_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_TRIG_VOLT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_TRIG_CURR = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_MENU = 4'hC;

    // ctrl fields
    localparam int F_IN_WIDTH = 0;
    localparam int F_ACTION = 8;
    localparam int F_OUT_STATE = 10;
    localparam int F_RECALL = 12;
    localparam int F_OUT_WIDTH = 16;
    localparam int F_OUT_LEVEL = 24;
    localparam int F_OUT_SOURCE = 26;

    // menu register fields
    localparam int F_ENTRY = 0;
    localparam int F_VALUE = 8;
    localparam int F_COMMIT = 31;

    localparam int ENTRY_W = 7;
    localparam int SET_W = 16;
    localparam logic [SET_W-1:0] RATED_VOLT = 16'h1770;
    localparam logic [SET_W-1:0] RATED_CURR = 16'h0FA0;
    localparam logic [13:0] PASSWORD_MAX = 14'h270F;
    localparam int COMMIT_CYCLES = 4;

    // function-entry boundaries
    localparam logic [ENTRY_W-1:0] E_RUN_A_LO = 7'h01;
    localparam logic [ENTRY_W-1:0] E_RUN_A_HI = 7'h3D;
    localparam logic [ENTRY_W-1:0] E_RUN_B_LO = 7'h46;
    localparam logic [ENTRY_W-1:0] E_RUN_B_HI = 7'h4E;
    localparam logic [ENTRY_W-1:0] E_RUN_C_LO = 7'h58;
    localparam logic [ENTRY_W-1:0] E_VERSION = 7'h59;
    localparam logic [ENTRY_W-1:0] E_POWER_LO = 7'h5A;
    localparam logic [ENTRY_W-1:0] E_POWER_HI = 7'h62;
    localparam logic [ENTRY_W-1:0] E_RUN_D_LO = 7'h64;
    localparam logic [ENTRY_W-1:0] E_RUN_D_HI = 7'h7A;
    localparam logic [ENTRY_W-1:0] E_PASSWORD = 7'h00;

    typedef enum logic [1:0] {ACT_NONE, ACT_OUTPUT, ACT_SETTING, ACT_MEMORY} action_type;
    typedef enum logic [1:0] {SRC_NONE, SRC_OUTPUT, SRC_SETTING, SRC_RECALL} source_type;

    typedef struct packed {
        logic [5:0] in_width;
        action_type action;
        logic out_state;
        logic [1:0] recall_slot;
        logic [5:0] out_width;
        logic out_level;
        source_type out_source;
    } trig_cfg_type;

    typedef struct packed {
        logic output_change;
        logic setting_change;
        logic recall;
    } trig_event_type;
endpackage : trig_cfg_pkg

// ### tb/trig_partner.sv
// Purpose: external gear on the trigger pins
// Assumes: bench clock; drive() is called right after the bench sets up
// Notes: keeps the length of the last high run on the trigger output
`timescale 1ns/1ps
module trig_partner (
    input wire logic clk,
    input wire logic trig_out,
    output logic trig_in
);
    int run = 0;
    int last_width = 0;
    initial trig_in = 1'b0;
    task automatic drive(input logic level);
        @(posedge clk);
        trig_in <= level;
    endtask : drive
    ////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        if (trig_out === 1'b1) begin
            run <= run + 1;
        end else begin
            if (run != 0) begin
                last_width <= run;
            end
            run <= 0;
        end
    end
endmodule : trig_partner

// ### tb/trigger_action_config_menu_bench.sv
// Purpose: self-checking bench for trigger handling and menu gating
// Assumes: Avalon-MM slave answers after one cycle
// Notes: millisecond counts run at full length, about 83k cycles
`timescale 1ns/1ps
module trigger_action_config_menu_bench;
    import trig_cfg_pkg::*;
    logic clk, rst, func_key, rd, wr, waitreq, trig_in, trig_out, output_on, rstrobe, pmode, cfg_ind, refused;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [15:0] volt, curr;
    logic [1:0] rslot;
    logic [13:0] spec;
    trig_event_type events;
    int num_errors = 0;
    int compares = 0;
    int strobes = 0;
    trigger_action_config_menu u_dut (.REF_CLK(clk), .RST(rst), .TRIG_IN(trig_in), .FUNC_KEY(func_key),
        .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .EVENTS(events),
        .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq), .TRIG_OUT(trig_out), .OUTPUT_ON(output_on),
        .VOLT_SETPOINT(volt), .CURR_SETPOINT(curr), .RECALL_STROBE(rstrobe), .RECALL_SLOT(rslot),
        .POWERUP_MODE(pmode), .CONFIGURING_INDICATOR(cfg_ind), .SPECIAL_FUNCTION(spec), .WRITE_REFUSED(refused));
    trig_partner u_p (.clk(clk), .trig_out(trig_out), .trig_in(trig_in));
    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        if (rstrobe === 1'b1) begin
            strobes <= strobes + 1;
        end
    end
    task automatic report_and_stop;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (98000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : cyc
    ////////////////////////////////////////////////////////////////
    task automatic bus(input logic is_wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= is_wr;
        rd <= !is_wr;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        q = rdata;
        check("bus_answer", n < 50, 1'b1);
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic set_ctrl(input int iw, act, ost, slot, ow, lvl, src);
        logic [31:0] w;
        w = 32'h0;
        w[F_IN_WIDTH +: 6] = iw[5:0];
        w[F_ACTION +: 2] = act[1:0];
        w[F_OUT_STATE] = ost[0];
        w[F_RECALL +: 2] = slot[1:0];
        w[F_OUT_WIDTH +: 6] = ow[5:0];
        w[F_OUT_LEVEL] = lvl[0];
        w[F_OUT_SOURCE +: 2] = src[1:0];
        bus(1'b1, OFS_TRIG_CTRL, w);
    endtask : set_ctrl
    task automatic fire;
        u_p.drive(1'b1);
        cyc(8);
        u_p.drive(1'b0);
        cyc(8);
    endtask : fire
    task automatic menu(input logic [6:0] e, input logic [15:0] v, input logic exp_ref);
        logic [31:0] w;
        w = {8'h00, v, 1'b0, e};
        bus(1'b1, OFS_MENU, w);
        w[F_COMMIT] = 1'b1;
        bus(1'b1, OFS_MENU, w);
        cyc(1);
        check("write_refused", refused, exp_ref);
        check("configuring", cfg_ind, !exp_ref);
        cyc(6);
        check("configuring_end", cfg_ind, 1'b0);
    endtask : menu
    ////////////////////////////////////////////////////////////////
    task automatic t_regs;
        set_ctrl(60, 0, 0, 1, 0, 0, 0);
        bus(1'b0, OFS_TRIG_CTRL, 32'h0);
        check("in_width_max", q[5:0], 6'h3C);
        set_ctrl(61, 0, 0, 1, 0, 0, 0);
        bus(1'b0, OFS_TRIG_CTRL, 32'h0);
        check("in_width_kept", q[5:0], 6'h3C);
        bus(1'b1, OFS_TRIG_VOLT, 32'h0000FFFF);
        bus(1'b0, OFS_TRIG_VOLT, 32'h0);
        check("volt_clamp", q, 32'h00001770);
        bus(1'b1, OFS_TRIG_CURR, 32'h0000FFFF);
        bus(1'b0, OFS_TRIG_CURR, 32'h0);
        check("curr_clamp", q, 32'h00000FA0);
        bus(1'b0, 4'h6, 32'h0);
        check("unmapped", q, 32'h0);
    endtask : t_regs
    task automatic t_setting;
        set_ctrl(0, 2, 0, 1, 0, 0, 0);
        fire;
        check("volt_max", volt, 16'h1770);
        check("curr_max", curr, 16'h0FA0);
        bus(1'b1, OFS_TRIG_VOLT, 32'h00000100);
        bus(1'b1, OFS_TRIG_CURR, 32'h00000200);
        fire;
        check("volt_load", volt, 16'h0100);
        check("curr_load", curr, 16'h0200);
        set_ctrl(0, 0, 0, 1, 0, 0, 0);
        bus(1'b1, OFS_TRIG_VOLT, 32'h00000300);
        fire;
        check("volt_idle", volt, 16'h0100);
    endtask : t_setting
    task automatic t_output;
        set_ctrl(0, 1, 1, 1, 0, 0, 0);
        fire;
        check("output_on", output_on, 1'b1);
        set_ctrl(0, 1, 0, 1, 0, 0, 0);
        fire;
        check("output_off", output_on, 1'b0);
        set_ctrl(0, 0, 1, 1, 0, 0, 0);
        fire;
        check("output_idle", output_on, 1'b0);
    endtask : t_output
    task automatic t_recall;
        int n0;
        for (int s = 1; s < 4; s++) begin
            n0 = strobes;
            set_ctrl(0, 3, 0, s, 0, 0, 0);
            fire;
            check("recall_slot", rslot, s[1:0]);
            check("recall_strobe", strobes - n0, 1);
        end
        set_ctrl(0, 3, 0, 0, 0, 0, 0);
        fire;
        check("recall_zero", rslot, 2'h3);
    endtask : t_recall
    task automatic t_in_width;
        set_ctrl(1, 1, 1, 1, 0, 0, 0);
        u_p.drive(1'b1);
        cyc(9000);
        check("width_early", output_on, 1'b0);
        cyc(12000);
        check("width_fired", output_on, 1'b1);
        u_p.drive(1'b0);
        cyc(5);
    endtask : t_in_width
    task automatic t_out;
        set_ctrl(0, 0, 0, 1, 0, 1, 0);
        cyc(3);
        check("level_high", trig_out, 1'b1);
        set_ctrl(0, 0, 0, 1, 0, 0, 0);
        cyc(3);
        check("level_low", trig_out, 1'b0);
        for (int s = 0; s < 4; s++) begin
            set_ctrl(0, 0, 0, 1, 1, 0, s);
            for (int k = 1; k < 5; k++) begin
                if (k != s && k < 4) begin
                    @(posedge clk);
                    events <= trig_event_type'(3'b100 >> (k - 1));
                    @(posedge clk);
                    events <= '0;
                    cyc(5);
                    check("trig_quiet", trig_out, 1'b0);
                end
            end
            if (s != 0) begin
                @(posedge clk);
                events <= trig_event_type'(3'b100 >> (s - 1));
                @(posedge clk);
                events <= '0;
                cyc(3);
                check("trig_fire", trig_out, 1'b1);
                cyc(20500);
                check("pulse_len", u_p.last_width >= TICK_CYCLES && u_p.last_width <= 2 * TICK_CYCLES + 2, 1'b1);
            end
        end
    endtask : t_out
    task automatic t_menu;
        logic [6:0] ents [16] = '{7'h01, 7'h3D, 7'h46, 7'h4E, 7'h58, 7'h64, 7'h7A, 7'h05,
                                 7'h3E, 7'h45, 7'h4F, 7'h59, 7'h5A, 7'h62, 7'h63, 7'h7B};
        for (int i = 0; i < 16; i++) begin
            menu(ents[i], 16'h0001, i >= 8);
        end
        menu(7'h00, 16'h270F, 1'b0);
        check("password_max", spec, 14'h270F);
        menu(7'h00, 16'h2710, 1'b1);
        check("password_kept", spec, 14'h270F);
    endtask : t_menu
    task automatic t_powerup;
        @(posedge clk);
        rst <= 1'b1;
        func_key <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        cyc(3);
        check("powerup_mode", pmode, 1'b1);
        check("reset_slot", rslot, 2'h1);
        menu(7'h5C, 16'h0001, 1'b0);
        menu(7'h05, 16'h0001, 1'b1);
    endtask : t_powerup
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        func_key = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        events = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        cyc(1);
        check("reset_wait", waitreq, 1'b1);
        check("reset_slot", rslot, 2'h1);
        check("reset_mode", pmode, 1'b0);
        t_regs;
        t_setting;
        t_output;
        t_recall;
        t_in_width;
        t_out;
        t_menu;
        t_powerup;
        report_and_stop;
    end
endmodule : trigger_action_config_menu_bench

// ### verilog/ms_tick.sv
// Purpose: one-cycle pulse every millisecond
// Assumes: REF_CLK at the package rate
// Notes: free running from reset
`timescale 1ns/1ps
module ms_tick (
    input wire logic clk,
    input wire logic rst,
    output logic tick
);
    import trig_cfg_pkg::*;
    logic [13:0] count;
    logic [13:0] next_count;
    logic next_tick;

    always_comb begin
        next_tick = 1'b0;
        next_count = count + 14'h0001;
        if (count == 14'(TICK_CYCLES - 1)) begin
            next_count = 14'h0000;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 14'h0000;
            tick <= 1'b0;
        end else begin
            count <= next_count;
            tick <= next_tick;
        end
    end
endmodule : ms_tick

// ### verilog/pulse_timer.sv
// Purpose: millisecond pulse stretcher for the trigger output
// Assumes: tick from ms_tick, start is one cycle wide
// Notes: width zero gives no pulse; caller then drives a static level
`timescale 1ns/1ps
module pulse_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic start,
    input wire logic [5:0] width,
    output logic busy
);
    import trig_cfg_pkg::*;
    logic [6:0] remain;
    logic [6:0] next_remain;

    // one extra count covers the partial first tick, so length is width..width+1 ms
    always_comb begin
        next_remain = remain;
        if (start && width != 6'h00) begin
            next_remain = {1'b0, width} + 7'h01;
        end else if (tick && remain != 7'h00) begin
            next_remain = remain - 7'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain <= 7'h00;
        end else begin
            remain <= next_remain;
        end
    end

    assign busy = remain != 7'h00;
endmodule : pulse_timer

// ### verilog/trigger_action_config_menu.sv
// Purpose: trigger input qualification, trigger actions, trigger output, function menu gating
// Assumes: single 10 MHz clock, asynchronous active-high reset, Avalon-MM slave
// Notes: TRIG_IN is an asynchronous pin; power-up window is POWERUP_MODE after reset
`timescale 1ns/1ps
//
// Operation
// [R1] input width 0..60 ms, zero follows level
// [R2] action 0 none,1 output,2 setting,3 recall
// [R3] output action drives off for 0, on 1
// [R4] action 2 loads clamped trigger voltage setpoint
// [R5] action 2 loads clamped trigger current setpoint
// [R6] recall slots 1..3 select memory slots; slot resets to 0, so a recall before a 1..3 write strobes slot 0
// [R7] output pulse 0..60 ms, zero holds level
// [R8] static output level low 0, high 1
// [R9] output fires on selected source event
// [R10] entries 90..98 editable only at power-up
// [R11] run-time edits only listed entry ranges
// [R12] firmware version entry is read-only
// [R13] password 0000..9999 selects special function; code checks only value bits 13:0 and ignores bits 15:14
// [R14] function key at power-up enters configuration
// [R15] knob press commits, shows configuring indicator
// [R16] millisecond tick times widths within one tick
module trigger_action_config_menu (
    input wire logic REF_CLK,
    input wire logic RST,
    input wire logic TRIG_IN,
    input wire logic FUNC_KEY,
    input wire logic [3:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire trig_cfg_pkg::trig_event_type EVENTS,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic TRIG_OUT,
    output logic OUTPUT_ON,
    output logic [15:0] VOLT_SETPOINT,
    output logic [15:0] CURR_SETPOINT,
    output logic RECALL_STROBE,
    output logic [1:0] RECALL_SLOT,
    output logic POWERUP_MODE,
    output logic CONFIGURING_INDICATOR,
    output logic [13:0] SPECIAL_FUNCTION,
    output logic WRITE_REFUSED
);
    import trig_cfg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // tick, input synchroniser
    logic tick;
    logic [2:0] trig_sync;
    logic trig_level;
    logic next_trig_level;

    ms_tick u_tick (
        .clk(REF_CLK),
        .rst(RST),
        .tick(tick)
    ); // [R16]

    always_comb begin
        next_trig_level = trig_level;
        if (trig_sync[2] == trig_sync[1]) begin
            next_trig_level = trig_sync[1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers
    trig_cfg_type cfg;
    trig_cfg_type next_cfg;
    logic [15:0] trig_volt;
    logic [15:0] next_trig_volt;
    logic [15:0] trig_curr;
    logic [15:0] next_trig_curr;
    logic [ENTRY_W-1:0] menu_entry;
    logic [ENTRY_W-1:0] next_menu_entry;
    logic [15:0] menu_value;
    logic [15:0] next_menu_value;
    logic [2:0] commit_count;
    logic [2:0] next_commit_count;
    logic next_powerup;
    logic next_refused;
    logic [13:0] next_special;
    logic [31:0] next_readdata;
    logic next_wait;
    logic editable;

    // entry classification
    always_comb begin
        editable = 1'b0;
        if (POWERUP_MODE) begin
            editable = menu_entry >= E_POWER_LO && menu_entry <= E_POWER_HI; // [R10] [R14]
        end else if ((menu_entry >= E_RUN_A_LO && menu_entry <= E_RUN_A_HI)
                || (menu_entry >= E_RUN_B_LO && menu_entry <= E_RUN_B_HI)
                || (menu_entry == E_RUN_C_LO)
                || (menu_entry >= E_RUN_D_LO && menu_entry <= E_RUN_D_HI)
                || menu_entry == E_PASSWORD) begin
            editable = 1'b1; // [R11] version entry excluded [R12]
        end
    end

    logic req;
    logic [15:0] wr_lo;
    assign req = (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
    assign wr_lo = AVS_WRITEDATA[15:0];

    always_comb begin
        next_cfg = cfg;
        next_trig_volt = trig_volt;
        next_trig_curr = trig_curr;
        next_menu_entry = menu_entry;
        next_menu_value = menu_value;
        next_commit_count = commit_count;
        next_powerup = POWERUP_MODE;
        next_refused = WRITE_REFUSED;
        next_special = SPECIAL_FUNCTION;
        next_readdata = AVS_READDATA;
        next_wait = 1'b1;
        if (commit_count != 3'h0) begin
            next_commit_count = commit_count - 3'h1; // [R15]
        end
        if (req) begin
            next_wait = 1'b0;
        end
        if (req && AVS_WRITE) begin
            unique case (AVS_ADDRESS)
                OFS_TRIG_CTRL: begin
                    if (AVS_WRITEDATA[F_IN_WIDTH +: 6] <= 6'(MAX_WIDTH_MS)) begin
                        next_cfg.in_width = AVS_WRITEDATA[F_IN_WIDTH +: 6]; // [R1]
                    end
                    next_cfg.action = action_type'(AVS_WRITEDATA[F_ACTION +: 2]);
                    next_cfg.out_state = AVS_WRITEDATA[F_OUT_STATE];
                    if (AVS_WRITEDATA[F_RECALL +: 2] != 2'h0) begin
                        next_cfg.recall_slot = AVS_WRITEDATA[F_RECALL +: 2];
                    end
                    if (AVS_WRITEDATA[F_OUT_WIDTH +: 6] <= 6'(MAX_WIDTH_MS)) begin
                        next_cfg.out_width = AVS_WRITEDATA[F_OUT_WIDTH +: 6]; // [R7]
                    end
                    next_cfg.out_level = AVS_WRITEDATA[F_OUT_LEVEL];
                    next_cfg.out_source = source_type'(AVS_WRITEDATA[F_OUT_SOURCE +: 2]);
                end
                OFS_TRIG_VOLT: begin
                    next_trig_volt = (wr_lo > RATED_VOLT) ? RATED_VOLT : wr_lo; // [R4]
                end
                OFS_TRIG_CURR: begin
                    next_trig_curr = (wr_lo > RATED_CURR) ? RATED_CURR : wr_lo; // [R5]
                end
                OFS_MENU: begin
                    next_menu_entry = AVS_WRITEDATA[F_ENTRY +: ENTRY_W];
                    next_menu_value = AVS_WRITEDATA[F_VALUE +: 16];
                    if (AVS_WRITEDATA[F_COMMIT]) begin
                        if (editable && (menu_entry != E_PASSWORD
                                || menu_value[13:0] <= PASSWORD_MAX)) begin
                            next_refused = 1'b0;
                            next_commit_count = 3'(COMMIT_CYCLES); // [R15]
                            if (menu_entry == E_PASSWORD) begin
                                next_special = menu_value[13:0]; // [R13]
                            end
                        end else begin
                            next_refused = 1'b1; // [R10] [R11] [R12]
                        end
                    end
                end
                default: begin
                end
            endcase
        end
        if (req && AVS_READ) begin
            unique case (AVS_ADDRESS)
                OFS_TRIG_CTRL: next_readdata = {4'h0, cfg.out_source, 1'b0, cfg.out_level,
                    2'h0, cfg.out_width, 2'h0, cfg.recall_slot, 1'b0, cfg.out_state,
                    cfg.action, 2'h0, cfg.in_width};
                OFS_TRIG_VOLT: next_readdata = {16'h0000, trig_volt};
                OFS_TRIG_CURR: next_readdata = {16'h0000, trig_curr};
                OFS_MENU: next_readdata = {commit_count != 3'h0, WRITE_REFUSED, POWERUP_MODE,
                    5'h00, menu_value, 1'b0, menu_entry};
                default: next_readdata = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger qualification and actions
    logic [6:0] hi_ms;
    logic [6:0] next_hi_ms;
    logic trig_prev;
    logic fire_in;
    logic next_output_on;
    logic [15:0] next_volt;
    logic [15:0] next_curr;
    logic next_recall;
    logic [1:0] next_slot;
    logic src_fire;
    logic pulse_busy;
    logic next_trig_out;

    always_comb begin
        next_hi_ms = hi_ms;
        fire_in = 1'b0;
        if (!trig_level) begin
            next_hi_ms = 7'h00;
        end else if (cfg.in_width == 6'h00) begin
            fire_in = !trig_prev; // [R1] level mode
        end else if (tick && hi_ms != 7'h7F) begin
            next_hi_ms = hi_ms + 7'h01;
            // partial first tick not counted, so qualified width is N..N+1 ms
            fire_in = hi_ms == {1'b0, cfg.in_width}; // [R1] [R16]
        end
    end

    always_comb begin
        next_output_on = OUTPUT_ON;
        next_volt = VOLT_SETPOINT;
        next_curr = CURR_SETPOINT;
        next_recall = 1'b0;
        next_slot = RECALL_SLOT;
        if (fire_in) begin
            unique case (cfg.action) // [R2]
                ACT_NONE: begin
                end
                ACT_OUTPUT: next_output_on = cfg.out_state; // [R3]
                ACT_SETTING: begin
                    next_volt = trig_volt; // [R4]
                    next_curr = trig_curr; // [R5]
                end
                ACT_MEMORY: begin
                    next_recall = 1'b1; // [R6]
                    next_slot = cfg.recall_slot;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // trigger output
    always_comb begin
        unique case (cfg.out_source) // [R9]
            SRC_NONE: src_fire = 1'b0;
            SRC_OUTPUT: src_fire = EVENTS.output_change;
            SRC_SETTING: src_fire = EVENTS.setting_change;
            SRC_RECALL: src_fire = EVENTS.recall;
        endcase
    end

    pulse_timer u_pulse (
        .clk(REF_CLK),
        .rst(RST),
        .tick(tick),
        .start(src_fire),
        .width(cfg.out_width),
        .busy(pulse_busy)
    ); // [R7]

    always_comb begin
        if (cfg.out_width == 6'h00) begin
            next_trig_out = cfg.out_level; // [R8]
        end else begin
            next_trig_out = pulse_busy || (src_fire && cfg.out_width != 6'h00); // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic powerup_seen;

    always_ff @(posedge REF_CLK or posedge RST) begin
        if (RST) begin
            trig_sync <= 3'h0;
            trig_level <= 1'b0;
            trig_prev <= 1'b0;
            hi_ms <= 7'h00;
            cfg <= '0;
            trig_volt <= 16'h0000;
            trig_curr <= 16'h0000;
            menu_entry <= 7'h01;
            menu_value <= 16'h0000;
            commit_count <= 3'h0;
            POWERUP_MODE <= 1'b0;
            powerup_seen <= 1'b0;
            WRITE_REFUSED <= 1'b0;
            SPECIAL_FUNCTION <= 14'h0000;
            AVS_READDATA <= 32'h00000000;
            AVS_WAITREQUEST <= 1'b1;
            TRIG_OUT <= 1'b0;
            OUTPUT_ON <= 1'b0;
            VOLT_SETPOINT <= 16'h0000;
            CURR_SETPOINT <= 16'h0000;
            RECALL_STROBE <= 1'b0;
            RECALL_SLOT <= 2'h1;
            CONFIGURING_INDICATOR <= 1'b0;
        end else begin
            trig_sync <= {trig_sync[1:0], TRIG_IN};
            trig_level <= next_trig_level;
            trig_prev <= trig_level;
            hi_ms <= next_hi_ms;
            cfg <= next_cfg;
            trig_volt <= next_trig_volt;
            trig_curr <= next_trig_curr;
            menu_entry <= next_menu_entry;
            menu_value <= next_menu_value;
            commit_count <= next_commit_count;
            // key sampled once, first edge after reset release
            powerup_seen <= 1'b1;
            POWERUP_MODE <= powerup_seen ? next_powerup : FUNC_KEY; // [R14]
            WRITE_REFUSED <= next_refused;
            SPECIAL_FUNCTION <= next_special;
            AVS_READDATA <= next_readdata;
            AVS_WAITREQUEST <= next_wait;
            TRIG_OUT <= next_trig_out;
            OUTPUT_ON <= next_output_on;
            VOLT_SETPOINT <= next_volt;
            CURR_SETPOINT <= next_curr;
            RECALL_STROBE <= next_recall;
            RECALL_SLOT <= next_slot;
            CONFIGURING_INDICATOR <= next_commit_count != 3'h0; // [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    a_setting_load: assert property (@(posedge REF_CLK) disable iff (RST)
        fire_in && cfg.action == ACT_SETTING |=> VOLT_SETPOINT == $past(trig_volt)) // [R4]
        else $error("voltage setpoint not loaded");
    a_curr_clamp: assert property (@(posedge REF_CLK) disable iff (RST)
        trig_curr <= RATED_CURR) // [R5]
        else $error("trigger current above rating");
    a_output_state: assert property (@(posedge REF_CLK) disable iff (RST)
        fire_in && cfg.action == ACT_OUTPUT |=> OUTPUT_ON == $past(cfg.out_state)) // [R3]
        else $error("output state wrong after trigger");
    a_no_action: assert property (@(posedge REF_CLK) disable iff (RST)
        fire_in && cfg.action == ACT_NONE |=> $stable(OUTPUT_ON) && !RECALL_STROBE) // [R2]
        else $error("action taken for code none");
    a_recall_slot: assert property (@(posedge REF_CLK) disable iff (RST)
        RECALL_STROBE |-> RECALL_SLOT != 2'h0) // [R6]
        else $error("recall of slot zero");
    a_static_level: assert property (@(posedge REF_CLK) disable iff (RST)
        cfg.out_width == 6'h00 && $stable(cfg) |=> TRIG_OUT == $past(cfg.out_level)) // [R8]
        else $error("static trigger level wrong");
    a_pulse_start: assert property (@(posedge REF_CLK) disable iff (RST)
        src_fire && cfg.out_width != 6'h00 |=> TRIG_OUT [*2]) // [R7] [R9]
        else $error("trigger pulse missing");
    a_version_ro: assert property (@(posedge REF_CLK) disable iff (RST)
        req && AVS_WRITE && AVS_ADDRESS == OFS_MENU && AVS_WRITEDATA[F_COMMIT]
        && menu_entry == E_VERSION |=> WRITE_REFUSED && !CONFIGURING_INDICATOR) // [R12]
        else $error("version entry edited");
    a_power_entries: assert property (@(posedge REF_CLK) disable iff (RST)
        req && AVS_WRITE && AVS_ADDRESS == OFS_MENU && AVS_WRITEDATA[F_COMMIT] && !POWERUP_MODE
        && menu_entry >= E_POWER_LO && menu_entry <= E_POWER_HI |=> WRITE_REFUSED) // [R10]
        else $error("power-on entry edited at run time");
    a_wait_one: assert property (@(posedge REF_CLK) disable iff (RST)
        (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer timing wrong");
endmodule : trigger_action_config_menu
